//--- shared/hrx_pkg.sv
// Shared constants for the receiver
package hrx_pkg;
   // -----------------------------------------------------------------
   // Register indices on the host port
   // -----------------------------------------------------------------
   localparam logic [4:0] REG_CONFIG   = 5'h00;
   localparam logic [4:0] REG_STATUS   = 5'h01;
   localparam logic [4:0] REG_MASK     = 5'h02;
   localparam logic [4:0] REG_IRQ_ACK  = 5'h03;
   localparam logic [4:0] REG_PKT_CNT  = 5'h04;
   localparam logic [4:0] REG_DROP_CNT = 5'h05;
   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int         CFG_DESCRAMBLE_BIT = 0;
   localparam int         CFG_FCS32_BIT      = 1;
   localparam logic [7:0] CONFIG_RESET       = 8'h00;
   localparam logic [7:0] MASK_RESET         = 8'h00;
   localparam int         ST_PKT_BIT         = 0;
   localparam int         ST_DROP_BIT        = 1;
   localparam int         ST_LEN_BIT         = 2;
   // -----------------------------------------------------------------
   // Framing octets and counts
   // -----------------------------------------------------------------
   localparam logic [7:0] FLAG_OCTET     = 8'h7e;
   localparam logic [7:0] ESC_OCTET      = 8'h7d;
   localparam logic [7:0] ESC_XOR        = 8'h20;
   localparam int         SCRAMBLE_TAPS  = 43;
   localparam int         LEN_CNT_W      = 16;
   localparam int         BUF_DEPTH      = 2;
   localparam logic [15:0] FCS16_GOOD    = 16'hf0b8;
   localparam logic [31:0] FCS32_GOOD    = 32'hdebb20e3;
endpackage

//--- shared/hrx_stream_if.sv
// Valid/ready octet stream between receiver modules
`timescale 1ns/10ps
interface hrx_stream_if;
   logic [9:0] data;
   logic       valid;
   logic       ready;
   modport src (output data, output valid, input ready);
   modport dst (input data, input valid, output ready);
endinterface

//--- logic/hrx_buffer.sv
// Two-entry octet buffer with valid/ready on both sides
`timescale 1ns/10ps
module hrx_buffer #(
   parameter int DEPTH = 2
) (
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   hrx_stream_if.dst   wr,
   hrx_stream_if.src   rd
);
   if (DEPTH != 2)
   begin : g_depth_check
      $error("hrx_buffer supports depth 2 only");
   end

   logic [9:0] mem [0:1];
   logic       wptr;
   logic       rptr;
   logic [1:0] count;
   logic       do_wr;
   logic       do_rd;

   assign wr.ready = (count != 2'd2);
   assign do_wr    = wr.valid && wr.ready;
   assign do_rd    = rd.valid && rd.ready;
   assign rd.valid = (count != 2'd0);
   assign rd.data  = mem[rptr];

   always_ff @(posedge clk_in)
   begin
      if (do_wr)
      begin
         mem[wptr] <= wr.data;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wptr  <= 1'b0;
         rptr  <= 1'b0;
         count <= 2'd0;
      end
      else
      begin
         if (do_wr)
         begin
            wptr <= ~wptr;
         end
         if (do_rd)
         begin
            rptr <= ~rptr;
         end
         count <= count + {1'b0, do_wr} - {1'b0, do_rd};
      end
   end
endmodule // hrx_buffer

//--- logic/hrx_receiver.sv
// Octet-wide HDLC receiver: descrambler, deframer, FCS, stats, host port
`timescale 1ns/10ps
// Notes on behaviour
// R1: 16-bit frame length counter, overflow pulse
// R2: Read strobe is one clock wide
// R3: Write strobe one clock wide with data
// R4: 5-bit index, 8-bit write bus
// R5: 8-bit read bus with read-valid
// R6: Interrupt on overflow, held until acknowledged
// R7: Soft reset is synchronous, active high
// R8: Hard reset is asynchronous, active high; outputs clear only at the next clock edge
// R9: Packet octets qualified by output valid
// R10: Last flag only with final octet
// R11: Drop flag meaningful only with last
// R12: PHY valid marks each input octet
// R13: Everything runs on one receive clock
// R14: Optional x^43+1 self-synchronous descrambler
// R15: Status register clears when read
// R16: Mask bit suppresses interrupt contribution
// R17: Drop on FCS error or invalid frame
// R18: Read-valid one clock per read strobe
module hrx_receiver (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   input  wire logic       hard_rst_in,
   input  wire logic [4:0] cpu_reg_index_in,
   input  wire logic       cpu_read_strobe_in,
   input  wire logic       cpu_write_strobe_in,
   input  wire logic [7:0] cpu_write_bus_in,
   output logic      [7:0] cpu_read_bus_out,
   output logic            cpu_read_valid_out,
   output logic            stats_irq_out,
   output logic            frame_len_overflow_pulse_out,
   input  wire logic [7:0] phy_in_bus_in,
   input  wire logic       phy_in_valid_in,
   output logic      [7:0] pkt_out_bus_out,
   output logic            pkt_out_valid_out,
   output logic            pkt_last_flag_out,
   output logic            pkt_drop_flag_out,
   input  wire logic       pkt_ready_in
);
   // -----------------------------------------------------------------
   // Reset merge: hard reset caught async, released on the clock
   // -----------------------------------------------------------------
   logic [1:0] hard_sync;
   logic       rst;

   always_ff @(posedge clk_in or posedge hard_rst_in)
   begin
      if (hard_rst_in)
         hard_sync <= 2'b11; // R8
      else
         hard_sync <= {hard_sync[0], 1'b0};
   end

   assign rst = hard_sync[1] | srst_in; // R7 R13

   // -----------------------------------------------------------------
   // CRC functions
   // -----------------------------------------------------------------
   function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
      return r;
   endfunction

   function automatic logic [31:0] crc32_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
      return r;
   endfunction

   // -----------------------------------------------------------------
   // Host registers
   // -----------------------------------------------------------------
   logic [7:0] config_reg;
   logic [7:0] mask_reg;
   logic [7:0] status_reg;
   logic [7:0] pkt_cnt;
   logic [7:0] drop_cnt;
   logic [7:0] status_set;
   logic       rd_status;

   assign rd_status = cpu_read_strobe_in && (cpu_reg_index_in == hrx_pkg::REG_STATUS);

   always_ff @(posedge clk_in)
   begin
      if (rst)
      begin
         config_reg <= hrx_pkg::CONFIG_RESET;
         mask_reg   <= hrx_pkg::MASK_RESET;
      end
      else if (cpu_write_strobe_in) // R3 R4
      begin
         if (cpu_reg_index_in == hrx_pkg::REG_CONFIG)
            config_reg <= cpu_write_bus_in;
         if (cpu_reg_index_in == hrx_pkg::REG_MASK)
            mask_reg <= cpu_write_bus_in;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst)
      begin
         cpu_read_bus_out   <= 8'h00;
         cpu_read_valid_out <= 1'b0;
      end
      else
      begin
         cpu_read_valid_out <= cpu_read_strobe_in; // R2 R5 R18
         if (cpu_read_strobe_in)
         begin
            case (cpu_reg_index_in)
               hrx_pkg::REG_CONFIG:   cpu_read_bus_out <= config_reg;
               hrx_pkg::REG_STATUS:   cpu_read_bus_out <= status_reg;
               hrx_pkg::REG_MASK:     cpu_read_bus_out <= mask_reg;
               hrx_pkg::REG_PKT_CNT:  cpu_read_bus_out <= pkt_cnt;
               hrx_pkg::REG_DROP_CNT: cpu_read_bus_out <= drop_cnt;
               default:               cpu_read_bus_out <= 8'h00;
            endcase
         end
      end
   end

   // Status clears on read, a same-cycle set wins
   always_ff @(posedge clk_in)
   begin
      if (rst)
         status_reg <= 8'h00;
      else if (rd_status)
         status_reg <= status_set; // R15
      else
         status_reg <= status_reg | status_set;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst)
         stats_irq_out <= 1'b0;
      else if ((status_set & ~mask_reg) != 8'h00) // R6 R16
         stats_irq_out <= 1'b1;
      else if (cpu_write_strobe_in && cpu_reg_index_in == hrx_pkg::REG_IRQ_ACK)
         stats_irq_out <= 1'b0; // R6
   end

   // -----------------------------------------------------------------
   // PHY capture and descrambler
   // -----------------------------------------------------------------
   logic [7:0]  phy_q;
   logic        phy_v;
   logic [42:0] scr_hist;
   logic [7:0]  desc;

   always_ff @(posedge clk_in)
   begin
      if (rst)
      begin
         phy_q <= 8'h00;
         phy_v <= 1'b0;
      end
      else
      begin
         phy_q <= phy_in_bus_in;
         phy_v <= phy_in_valid_in; // R12 R13
      end
   end

   // Bit 7 enters the line first; output = in ^ in delayed 43 bits
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         desc[i] = phy_q[i] ^ scr_hist[hrx_pkg::SCRAMBLE_TAPS - 8 + i];
      end
      if (!config_reg[hrx_pkg::CFG_DESCRAMBLE_BIT])
         desc = phy_q; // R14
   end

   always_ff @(posedge clk_in)
   begin
      if (rst)
         scr_hist <= '0;
      else if (phy_v)
         scr_hist <= {scr_hist[34:0], phy_q}; // R14
   end

   // -----------------------------------------------------------------
   // Deframer: flags, escapes, FCS and length
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {HRX_HUNT, HRX_DATA, HRX_ESC} hrx_state_t;
   hrx_state_t  state;
   logic [15:0] len_cnt;
   logic [15:0] crc16;
   logic [31:0] crc32;
   logic        bad;
   logic [7:0]  oct;
   logic [7:0]  hold;
   logic        hold_v;
   logic        emit;
   logic        emit_last;
   logic        emit_drop;
   logic        fcs_ok;
   logic        take;
   hrx_stream_if buf_in ();
   hrx_stream_if buf_out ();

   assign take   = phy_v && buf_in.ready;
   assign oct    = (state == HRX_ESC) ? (desc ^ hrx_pkg::ESC_XOR) : desc;
   assign fcs_ok = config_reg[hrx_pkg::CFG_FCS32_BIT] ? (crc32 == hrx_pkg::FCS32_GOOD)
                                                     : (crc16 == hrx_pkg::FCS16_GOOD);

   always_ff @(posedge clk_in)
   begin
      if (rst)
      begin
         state     <= HRX_HUNT;
         len_cnt   <= 16'h0000;
         crc16     <= 16'hffff;
         crc32     <= 32'hffffffff;
         bad       <= 1'b0;
         hold      <= 8'h00;
         hold_v    <= 1'b0;
         emit      <= 1'b0;
         emit_last <= 1'b0;
         emit_drop <= 1'b0;
         frame_len_overflow_pulse_out <= 1'b0;
      end
      else
      begin
         emit <= 1'b0;
         frame_len_overflow_pulse_out <= 1'b0;
         if (take)
         begin
            case (state)
               HRX_HUNT:
               begin
                  if (desc == hrx_pkg::FLAG_OCTET)
                     state <= HRX_DATA;
               end
               HRX_DATA, HRX_ESC:
               begin
                  if (desc == hrx_pkg::FLAG_OCTET)
                  begin
                     state <= HRX_DATA;
                     if (hold_v)
                     begin
                        emit      <= 1'b1;
                        emit_last <= 1'b1; // R10
                        emit_drop <= bad || !fcs_ok || (state == HRX_ESC); // R17
                     end
                     hold_v  <= 1'b0;
                     len_cnt <= 16'h0000;
                     bad     <= 1'b0;
                     crc16   <= 16'hffff;
                     crc32   <= 32'hffffffff;
                  end
                  else if (state == HRX_DATA && desc == hrx_pkg::ESC_OCTET)
                     state <= HRX_ESC;
                  else
                  begin
                     state     <= HRX_DATA;
                     hold      <= oct;
                     hold_v    <= 1'b1;
                     emit      <= hold_v;
                     emit_last <= 1'b0;
                     emit_drop <= 1'b0;
                     crc16     <= crc16_step(crc16, oct);
                     crc32     <= crc32_step(crc32, oct);
                     len_cnt   <= len_cnt + 16'h0001;
                     if (len_cnt == 16'hffff)
                     begin
                        frame_len_overflow_pulse_out <= 1'b1; // R1
                        bad <= 1'b1;
                     end
                  end
               end
               default: state <= HRX_HUNT;
            endcase
         end
      end
   end

   // Emitted octet is the one held before the newest, so last lines up
   logic [7:0] emit_data;
   always_ff @(posedge clk_in)
   begin
      if (rst)
         emit_data <= 8'h00;
      else if (take && state != HRX_HUNT && desc != hrx_pkg::FLAG_OCTET)
         emit_data <= hold;
      else if (take && desc == hrx_pkg::FLAG_OCTET)
         emit_data <= hold;
   end

   assign buf_in.data  = {emit_drop, emit_last, emit_data};
   assign buf_in.valid = emit;

   hrx_buffer #(
      .DEPTH (hrx_pkg::BUF_DEPTH)
   ) u_buf (
      .clk_in (clk_in),
      .rst_in (rst),
      .wr     (buf_in),
      .rd     (buf_out)
   );

   // -----------------------------------------------------------------
   // Packet output and statistics
   // -----------------------------------------------------------------
   assign buf_out.ready = !pkt_out_valid_out || pkt_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (rst)
      begin
         pkt_out_bus_out   <= 8'h00;
         pkt_out_valid_out <= 1'b0;
         pkt_last_flag_out <= 1'b0;
         pkt_drop_flag_out <= 1'b0;
      end
      else if (buf_out.ready)
      begin
         pkt_out_valid_out <= buf_out.valid; // R9
         pkt_out_bus_out   <= buf_out.data[7:0];
         pkt_last_flag_out <= buf_out.valid && buf_out.data[8]; // R10
         pkt_drop_flag_out <= buf_out.valid && buf_out.data[8] && buf_out.data[9]; // R11
      end
   end

   logic end_frame;
   assign end_frame = emit && emit_last && buf_in.ready;

   always_comb
   begin
      status_set = 8'h00;
      status_set[hrx_pkg::ST_PKT_BIT]  = end_frame && (pkt_cnt == 8'hff);
      status_set[hrx_pkg::ST_DROP_BIT] = end_frame && emit_drop && (drop_cnt == 8'hff);
      status_set[hrx_pkg::ST_LEN_BIT]  = frame_len_overflow_pulse_out;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst)
      begin
         pkt_cnt  <= 8'h00;
         drop_cnt <= 8'h00;
      end
      else if (end_frame)
      begin
         pkt_cnt <= pkt_cnt + 8'h01;
         if (emit_drop)
            drop_cnt <= drop_cnt + 8'h01;
      end
   end
endmodule // hrx_receiver

//--- testbench/hrx_receiver_properties.sv
// Port timing checker for the receiver
`timescale 1ns/10ps
module hrx_receiver_properties (
   input wire logic       clk_in,
   input wire logic       srst_in,
   input wire logic       hard_rst_in,
   input wire logic [4:0] cpu_reg_index_in,
   input wire logic       cpu_read_strobe_in,
   input wire logic       cpu_write_strobe_in,
   input wire logic [7:0] cpu_read_bus_out,
   input wire logic       cpu_read_valid_out,
   input wire logic       stats_irq_out,
   input wire logic       frame_len_overflow_pulse_out,
   input wire logic       phy_in_valid_in,
   input wire logic [7:0] pkt_out_bus_out,
   input wire logic       pkt_out_valid_out,
   input wire logic       pkt_last_flag_out,
   input wire logic       pkt_drop_flag_out,
   input wire logic       pkt_ready_in
);
   // ----------------------------------------------
   // Assertions
   // ----------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in || hard_rst_in);
   AST_READ_ANSWER: assert property (cpu_read_strobe_in |=> cpu_read_valid_out)
      else $error("read strobe not answered");
   AST_READ_CAUSE: assert property (cpu_read_valid_out |-> $past(cpu_read_strobe_in))
      else $error("read valid without strobe");
   AST_READ_PULSE: assert property (cpu_read_valid_out && !cpu_read_strobe_in
      |=> !cpu_read_valid_out)
      else $error("read valid longer than one cycle");
   AST_READ_HOLD: assert property (!cpu_read_valid_out |-> $stable(cpu_read_bus_out))
      else $error("read bus moved without read");
   AST_OUT_HOLD: assert property (pkt_out_valid_out && !pkt_ready_in |=> pkt_out_valid_out
      && $stable(pkt_out_bus_out) && $stable(pkt_last_flag_out))
      else $error("stalled octet not held");
   AST_LAST_QUAL: assert property (pkt_last_flag_out |-> pkt_out_valid_out)
      else $error("last flag without valid octet");
   AST_OVF_PULSE: assert property (frame_len_overflow_pulse_out
      |=> !frame_len_overflow_pulse_out)
      else $error("overflow pulse too long");
   AST_IRQ_HOLD: assert property (stats_irq_out && !(cpu_write_strobe_in
      && cpu_reg_index_in == hrx_pkg::REG_IRQ_ACK) |=> stats_irq_out)
      else $error("interrupt fell without acknowledge");
   AST_IDLE_QUIET: assert property ((!phy_in_valid_in && pkt_ready_in)[*8]
      |=> !pkt_out_valid_out)
      else $error("octet out without input");
   AST_DROP_QUAL: assert property (pkt_drop_flag_out |-> pkt_last_flag_out)
      else $error("drop flag without last flag");
endmodule // hrx_receiver_properties

//--- testbench/hrx_pkt_sink.sv
// Packet consumer model with optional stalls
`timescale 1ns/10ps
module hrx_pkt_sink (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic stall_in,
   input  wire logic valid_in,
   input  wire logic last_in,
   input  wire logic drop_in,
   output logic      ready_out,
   output int        npkt_out,
   output int        ndrop_out
);
   logic [7:0] lfsr;
   // Ready drops about one cycle in four while stalling, never twice running
   always_ff @(posedge clk_in)
   begin
      lfsr <= srst_in ? 8'h5b : {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      ready_out <= !stall_in || !ready_out || (lfsr[1:0] != 2'h0);
   end
   // Drop is sampled only together with last
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         npkt_out <= 0;
         ndrop_out <= 0;
      end
      else if (valid_in && ready_out && last_in)
      begin
         npkt_out <= npkt_out + 1;
         ndrop_out <= ndrop_out + (drop_in ? 1 : 0);
      end
   end
endmodule // hrx_pkt_sink

//--- testbench/tb_hrx_receiver.sv
// Self-checking bench for the receiver
`timescale 1ns/10ps
module tb_hrx_receiver;
   logic       clk_in = 1'b0;
   logic       srst_in = 1'b1;
   logic       hard_rst_in = 1'b0;
   logic [4:0] idx = 5'h00;
   logic       rds = 1'b0;
   logic       wrs = 1'b0;
   logic       phv = 1'b0;
   logic       stall = 1'b0;
   logic [7:0] wdat = 8'h00;
   logic [7:0] phy = 8'h00;
   logic [7:0] rdat, pdat, r;
   logic       rv, irq, ovf, pv, pl, pd, prdy;
   logic [31:0] seed = 32'h0000001a;
   logic [42:0] sh = 43'h0;
   logic       scr = 1'b0;
   logic       f32 = 1'b0;
   logic [7:0] eq[$];
   logic       el[$], ed[$];
   int         fails = 0, n_checks = 0, cyc = 0, nbad = 0, novf = 0, nfr = 0, npkt, ndrop;

   hrx_receiver u_dut (
      .clk_in(clk_in), .srst_in(srst_in), .hard_rst_in(hard_rst_in),
      .cpu_reg_index_in(idx), .cpu_read_strobe_in(rds), .cpu_write_strobe_in(wrs),
      .cpu_write_bus_in(wdat), .cpu_read_bus_out(rdat), .cpu_read_valid_out(rv),
      .stats_irq_out(irq), .frame_len_overflow_pulse_out(ovf),
      .phy_in_bus_in(phy), .phy_in_valid_in(phv), .pkt_out_bus_out(pdat),
      .pkt_out_valid_out(pv), .pkt_last_flag_out(pl), .pkt_drop_flag_out(pd),
      .pkt_ready_in(prdy)
   );
   hrx_pkt_sink u_sink (
      .clk_in(clk_in), .srst_in(srst_in), .stall_in(stall), .valid_in(pv),
      .last_in(pl), .drop_in(pd), .ready_out(prdy), .npkt_out(npkt), .ndrop_out(ndrop)
   );

   // ----------------------------------------------
   // Helpers
   // ----------------------------------------------
   initial forever #12.5 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (e !== g)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] b);
      c = c ^ {24'h000000, b};
      for (int k = 0; k < 8; k++)
         c = c[0] ? (c >> 1) ^ (f32 ? 32'hedb88320 : 32'h00008408) : c >> 1;
      return c;
   endfunction
   task automatic hreg(bit w, logic [4:0] a, logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      idx <= a;
      wdat <= d;
      rds <= !w;
      wrs <= w;
      @(posedge clk_in);
      rds <= 1'b0;
      wrs <= 1'b0;
      #1;
      if (!w) chk("read_valid", 1, rv);
      q = rdat;
   endtask
   // Line octet, scrambled when scr is set; sh holds the last 43 line bits
   task automatic put(logic [7:0] b, bit gap);
      logic [7:0] o;
      for (int j = 7; j >= 0; j--)
      begin
         o[j] = b[j] ^ (scr & sh[42]);
         sh = {sh[41:0], o[j]};
      end
      @(posedge clk_in);
      phy <= o;
      phv <= 1'b1;
      if (gap)
      begin
         @(posedge clk_in);
         phv <= 1'b0;
         phy <= ~b;
      end
   endtask
   // Payload of n octets, random where fill is zero, then FCS and flags
   task automatic frame(int n, bit bad, bit gap, logic [7:0] fill);
      logic [7:0] q[$];
      logic [31:0] c;
      c = f32 ? 32'hffffffff : 32'h0000ffff;
      for (int i = 0; i < n; i++) q.push_back(fill == 8'h00 ? rnd() : fill);
      foreach (q[i]) c = crc(c, q[i]);
      c = ~c ^ {31'h00000000, bad};
      for (int i = 0; i < (f32 ? 4 : 2); i++) q.push_back(c[8 * i +: 8]);
      foreach (q[i]) eq.push_back(q[i]);
      foreach (q[i]) el.push_back(i == q.size() - 1);
      ed.push_back(bad || n + (f32 ? 4 : 2) > 65535);
      nfr++;
      put(hrx_pkg::FLAG_OCTET, gap);
      foreach (q[i])
      begin
         if (q[i] == hrx_pkg::FLAG_OCTET || q[i] == hrx_pkg::ESC_OCTET)
         begin
            put(hrx_pkg::ESC_OCTET, gap);
            put(q[i] ^ hrx_pkg::ESC_XOR, gap);
         end
         else
            put(q[i], gap);
      end
      put(hrx_pkg::FLAG_OCTET, 1'b1);
   endtask
   always @(posedge clk_in)
   begin
      if (ovf === 1'b1) novf++;
      if (pv === 1'b1 && prdy === 1'b1)
      begin
         if (eq.size() == 0)
            chk("extra_octet", 0, 1);
         else
         begin
            chk("pkt_data", eq.pop_front(), pdat);
            chk("pkt_last", el[0], pl);
            if (el.pop_front()) chk("pkt_drop", ed.pop_front(), pd);
         end
      end
   end

   // ----------------------------------------------
   // Main sequence
   // ----------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      hreg(1, hrx_pkg::REG_CONFIG, 8'h02, r);
      hreg(0, hrx_pkg::REG_CONFIG, 8'h00, r);
      chk("config", 8'h02, r);
      hreg(1, hrx_pkg::REG_CONFIG, 8'h00, r);
      hreg(0, 5'h1f, 8'h00, r);
      chk("unmapped", 8'h00, r);
      stall <= 1'b1;
      frame(2, 0, 1, hrx_pkg::FLAG_OCTET);
      frame(3, 1, 1, hrx_pkg::ESC_OCTET);
      nbad++;
      repeat (24)
      begin
         r = rnd();
         nbad += r[7];
         frame(3 + r[2:0], r[7], 1, 8'h00);
      end
      stall <= 1'b0;
      repeat (40) @(posedge clk_in);
      chk("queue_empty", 0, eq.size());
      hreg(0, hrx_pkg::REG_DROP_CNT, 8'h00, r);
      chk("drop_count", nbad, r);
      frame(65540, 0, 0, 8'h11);
      repeat (40) @(posedge clk_in);
      chk("ovf_pulses", 1, novf);
      chk("irq_set", 1, irq);
      hreg(0, hrx_pkg::REG_STATUS, 8'h00, r);
      chk("status", 8'h04, r);
      hreg(0, hrx_pkg::REG_STATUS, 8'h00, r);
      chk("status_clr", 8'h00, r);
      chk("irq_held", 1, irq);
      hreg(1, hrx_pkg::REG_IRQ_ACK, 8'hff, r);
      repeat (2) @(posedge clk_in);
      chk("irq_ack", 0, irq);
      chk("sink_pkts", nfr, npkt);
      chk("sink_drops", nbad + 1, ndrop);
      put(hrx_pkg::FLAG_OCTET, 0);
      put(8'h3c, 1);
      #3 hard_rst_in = 1'b1;
      sh = 43'h0;
      #1 chk("hard_pv", 0, pv);
      chk("hard_rv", 0, rv);
      repeat (2) @(posedge clk_in);
      hard_rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      hreg(0, hrx_pkg::REG_DROP_CNT, 8'h00, r);
      chk("drop_after_hard", 8'h00, r);
      hreg(1, hrx_pkg::REG_MASK, 8'h01, r);
      hreg(1, hrx_pkg::REG_CONFIG, 8'h03, r);
      scr = 1'b1;
      f32 = 1'b1;
      frame(5, 0, 1, 8'h00);
      frame(6, 1, 1, 8'h00);
      repeat (254) frame(0, 0, 0, 8'h00);
      repeat (40) @(posedge clk_in);
      #1 chk("irq_masked", 0, irq);
      hreg(0, hrx_pkg::REG_STATUS, 8'h00, r);
      chk("status_wrap", 8'h01, r);
      repeat (40) @(posedge clk_in);
      chk("queue_final", 0, eq.size());
      finish_test();
   end
endmodule // tb_hrx_receiver

bind hrx_receiver hrx_receiver_properties u_props (
   .clk_in                       (clk_in),
   .srst_in                      (srst_in),
   .hard_rst_in                  (hard_rst_in),
   .cpu_reg_index_in             (cpu_reg_index_in),
   .cpu_read_strobe_in           (cpu_read_strobe_in),
   .cpu_write_strobe_in          (cpu_write_strobe_in),
   .cpu_read_bus_out             (cpu_read_bus_out),
   .cpu_read_valid_out           (cpu_read_valid_out),
   .stats_irq_out                (stats_irq_out),
   .frame_len_overflow_pulse_out (frame_len_overflow_pulse_out),
   .phy_in_valid_in              (phy_in_valid_in),
   .pkt_out_bus_out              (pkt_out_bus_out),
   .pkt_out_valid_out            (pkt_out_valid_out),
   .pkt_last_flag_out            (pkt_last_flag_out),
   .pkt_drop_flag_out            (pkt_drop_flag_out),
   .pkt_ready_in                 (pkt_ready_in)
);
